/* File: rtl/drpc_frac_div.sv */
// fractional feedback divider ratio sequencer
`timescale 1ns/1ps
`default_nettype none
module drpc_frac_div #(
  parameter int INT_W = drpc_pkg::INT_W,
  parameter int FRAC_W = drpc_pkg::FRAC_W
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic ce, // clock enable, freezes state when low
  input wire logic fb_tick, // one feedback cycle ends
  input wire logic [INT_W-1:0] int_field, // divisor minus one
  input wire logic [FRAC_W-1:0] num, // fraction numerator
  input wire logic [FRAC_W-1:0] modulus, // fraction modulus, zero bypasses
  output logic [INT_W:0] ratio, // divide ratio of the next feedback cycle
  output logic carry // this cycle took the extra count
);

  localparam logic [INT_W:0] STEP_ONE = (INT_W+1)'(1);
  localparam logic [INT_W:0] STEP_TWO = (INT_W+1)'(2);

  // refuse widths the accumulator cannot serve
  if (INT_W < 1 || FRAC_W < 1 || FRAC_W > 31)
  begin : g_chk
    $error("drpc_frac_div: unsupported width");
  end

  typedef struct packed {
    logic [FRAC_W:0] acc;
    logic [INT_W:0] ratio;
    logic carry;
  } drpc_fd_st_t;

  localparam drpc_fd_st_t ST_RST = '{acc: '0, ratio: STEP_ONE, carry: 1'b0};

  drpc_fd_st_t s_q;
  drpc_fd_st_t s_d;
  logic [FRAC_W:0] sum;

  // accumulate numerator once per feedback cycle
  always_comb
  begin
    s_d = s_q;
    sum = s_q.acc + {1'b0, num};
    if (fb_tick)
    begin
      if (modulus == '0)
      begin
        s_d.acc = '0;
        s_d.carry = 1'b0;
        s_d.ratio = {1'b0, int_field} + STEP_ONE;
      end
      else if (sum >= {1'b0, modulus})
      begin
        s_d.acc = sum - {1'b0, modulus};
        s_d.carry = 1'b1;
        s_d.ratio = {1'b0, int_field} + STEP_TWO;
      end
      else
      begin
        s_d.acc = sum;
        s_d.carry = 1'b0;
        s_d.ratio = {1'b0, int_field} + STEP_ONE;
      end
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= ST_RST;
    else if (ce)
      s_q <= s_d;
  end

  assign ratio = s_q.ratio;
  assign carry = s_q.carry;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bypass_int_only: assert property (ce && fb_tick && modulus == '0 |=>
    ratio == $past({1'b0, int_field}) + STEP_ONE && !carry)
    else $error("bypassed divider did not give integer ratio");
  a_zero_field_one: assert property (ce && fb_tick && modulus == '0 && int_field == '0
    |=> ratio == STEP_ONE)
    else $error("zero divisor field is not division by one");
  a_frac_carry_step: assert property (ce && fb_tick && modulus != '0
    && sum >= {1'b0, modulus} |=> ratio == $past({1'b0, int_field}) + STEP_TWO && carry)
    else $error("fraction carry did not add one count");
  a_frac_no_carry: assert property (ce && fb_tick && modulus != '0
    && sum < {1'b0, modulus} |=> ratio == $past({1'b0, int_field}) + STEP_ONE && !carry)
    else $error("fraction without carry changed ratio");
  c_frac_carry: cover property (ce && fb_tick && modulus != '0 ##1 carry);

endmodule
`default_nettype wire

/* File: rtl/drpc_pkg.sv */
// constants and types for the reference profile configuration block
package drpc_pkg;

  // word index of each register, byte address is four times the index
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] IDX_REF_CTRL = 12'h440;
  localparam logic [IDX_W-1:0] IDX_BW_LOW = 12'h441;
  localparam logic [IDX_W-1:0] IDX_BW_MID = 12'h442;
  localparam logic [IDX_W-1:0] IDX_BW_TOP = 12'h443;
  localparam logic [IDX_W-1:0] IDX_INT_LOW = 12'h444;
  localparam logic [IDX_W-1:0] IDX_INT_MID = 12'h445;
  localparam logic [IDX_W-1:0] IDX_INT_TOP = 12'h446;
  localparam logic [IDX_W-1:0] IDX_NUM_LOW = 12'h447;
  localparam logic [IDX_W-1:0] IDX_NUM_MID = 12'h448;
  localparam logic [IDX_W-1:0] IDX_NUM_HIGH = 12'h449;
  localparam logic [IDX_W-1:0] IDX_MOD_LOW = 12'h44a;
  localparam logic [IDX_W-1:0] IDX_MOD_MID = 12'h44b;
  localparam logic [IDX_W-1:0] IDX_MOD_HIGH = 12'h44c;

  // bus layout
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int WORD_LSB = 2;
  localparam int IDX_TOP_BIT = WORD_LSB + IDX_W;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field widths
  localparam int BW_W = 17;
  localparam int INT_W = 18;
  localparam int FRAC_W = 24;
  localparam int PRIO_W = 2;

  // field positions inside the byte registers
  localparam int REF_EN_BIT = 0;
  localparam int PRIO_LSB = 1;
  localparam int BW_TOP_BIT = 0;
  localparam int FILT_BIT = 1;
  localparam int INT_TOP_W = 2;

  // reset values
  localparam logic [BW_W-1:0] BW_RST = 17'h0;
  localparam logic [INT_W-1:0] INT_RST = 18'h0;
  localparam logic [FRAC_W-1:0] FRAC_RST = 24'h0;
  localparam logic [PRIO_W-1:0] PRIO_RST = 2'h0;
  localparam logic FILT_RST = 1'b0;
  localparam logic REF_EN_RST = 1'b0;

  // write and read channel states, one-hot
  typedef enum logic [1:0] {
    DRPC_WR_IDLE = 2'h1,
    DRPC_WR_RESP = 2'h2
  } drpc_wst_t;

  typedef enum logic [1:0] {
    DRPC_RD_IDLE = 2'h1,
    DRPC_RD_DATA = 2'h2
  } drpc_rst_t;

endpackage

/* File: rtl/drpc_top.sv */
// axi4-lite register bank for the first loop reference profile
`timescale 1ns/1ps
`default_nettype none
module drpc_top #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk, // system clock, 125 mhz
  input wire logic aresetn, // synchronous reset, low active
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic fb_tick, // feedback cycle boundary from loop
  output logic lock_permit, // loop may lock to first reference
  output logic [1:0] ref_priority, // first reference priority level
  output logic [16:0] bw_scale, // loop bandwidth, 0.1 hz units
  output logic filter_high_pm, // high phase margin filter chosen
  output logic [17:0] int_div_field, // integer divisor minus one
  output logic [23:0] frac_numerator, // fraction numerator
  output logic [23:0] frac_modulus, // fraction modulus
  output logic frac_bypass, // fractional divider bypassed
  output logic [18:0] fb_ratio, // divide ratio for next feedback cycle
  output logic fb_carry // feedback cycle took the extra count
);

  localparam int BW = drpc_pkg::BYTE_W;
  localparam int IW = drpc_pkg::IDX_W;

  // refuse an address bus too narrow for the map
  if (ADDR_W <= drpc_pkg::IDX_TOP_BIT)
  begin : g_chk
    $error("drpc_top: ADDR_W too small for the register map");
  end

  typedef struct packed {
    drpc_pkg::drpc_wst_t wst;
    logic aw_held;
    logic [IW-1:0] aw_idx;
    logic aw_hit;
    logic w_held;
    logic [BW-1:0] w_byte;
    logic w_lane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    drpc_pkg::drpc_rst_t rst;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ref_en;
    logic [drpc_pkg::PRIO_W-1:0] prio;
    logic [drpc_pkg::BW_W-1:0] bw;
    logic filt;
    logic [drpc_pkg::INT_W-1:0] ndiv;
    logic [drpc_pkg::FRAC_W-1:0] num;
    logic [drpc_pkg::FRAC_W-1:0] modulus;
    logic bypass;
  } drpc_st_t;

  localparam drpc_st_t ST_RST = '{
    wst: drpc_pkg::DRPC_WR_IDLE, aw_held: 1'b0, aw_idx: '0, aw_hit: 1'b0,
    w_held: 1'b0, w_byte: '0, w_lane: 1'b0, awready: 1'b1, wready: 1'b1,
    bvalid: 1'b0, bresp: drpc_pkg::RESP_OKAY, rst: drpc_pkg::DRPC_RD_IDLE,
    arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: drpc_pkg::RESP_OKAY,
    ref_en: drpc_pkg::REF_EN_RST, prio: drpc_pkg::PRIO_RST, bw: drpc_pkg::BW_RST,
    filt: drpc_pkg::FILT_RST, ndiv: drpc_pkg::INT_RST, num: drpc_pkg::FRAC_RST,
    modulus: drpc_pkg::FRAC_RST, bypass: 1'b1};

  drpc_st_t s_q;
  drpc_st_t s_d;

  // word index of a byte address
  function automatic logic [IW-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    return a[drpc_pkg::IDX_TOP_BIT-1:drpc_pkg::WORD_LSB];
  endfunction

  // address falls on a mapped register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [IW-1:0] i;
    i = addr_idx(a);
    return (a[ADDR_W-1:drpc_pkg::IDX_TOP_BIT] == '0)
      && (i >= drpc_pkg::IDX_REF_CTRL) && (i <= drpc_pkg::IDX_MOD_HIGH);
  endfunction

  // byte image of a register, reserved bits zero
  function automatic logic [BW-1:0] reg_byte(input drpc_st_t s, input logic [IW-1:0] i);
    logic [BW-1:0] b;
    b = '0;
    case (i)
      drpc_pkg::IDX_REF_CTRL:
      begin
        b[drpc_pkg::REF_EN_BIT] = s.ref_en;
        b[drpc_pkg::PRIO_LSB +: drpc_pkg::PRIO_W] = s.prio;
      end
      drpc_pkg::IDX_BW_LOW: b = s.bw[0 +: BW];
      drpc_pkg::IDX_BW_MID: b = s.bw[BW +: BW];
      drpc_pkg::IDX_BW_TOP:
      begin
        b[drpc_pkg::BW_TOP_BIT] = s.bw[drpc_pkg::BW_W-1];
        b[drpc_pkg::FILT_BIT] = s.filt;
      end
      drpc_pkg::IDX_INT_LOW: b = s.ndiv[0 +: BW];
      drpc_pkg::IDX_INT_MID: b = s.ndiv[BW +: BW];
      drpc_pkg::IDX_INT_TOP: b[drpc_pkg::INT_TOP_W-1:0] = s.ndiv[2*BW +: drpc_pkg::INT_TOP_W];
      drpc_pkg::IDX_NUM_LOW: b = s.num[0 +: BW];
      drpc_pkg::IDX_NUM_MID: b = s.num[BW +: BW];
      drpc_pkg::IDX_NUM_HIGH: b = s.num[2*BW +: BW];
      drpc_pkg::IDX_MOD_LOW: b = s.modulus[0 +: BW];
      drpc_pkg::IDX_MOD_MID: b = s.modulus[BW +: BW];
      drpc_pkg::IDX_MOD_HIGH: b = s.modulus[2*BW +: BW];
      default: b = '0;
    endcase
    return b;
  endfunction

  logic wr_fire;
  assign wr_fire = ce && s_q.wst == drpc_pkg::DRPC_WR_IDLE && s_q.aw_held && s_q.w_held
    && s_q.aw_hit && s_q.w_lane;

  // bus channels and register updates
  always_comb
  begin
    s_d = s_q;
    // address and data taken in either order
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_idx = addr_idx(s_axi_awaddr);
      s_d.aw_hit = addr_hit(s_axi_awaddr);
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_held = 1'b1;
      s_d.w_byte = s_axi_wdata[BW-1:0];
      s_d.w_lane = s_axi_wstrb[0];
      s_d.wready = 1'b0;
    end
    case (s_q.wst)
      drpc_pkg::DRPC_WR_IDLE:
      begin
        if (s_q.aw_held && s_q.w_held)
        begin
          if (s_q.aw_hit && s_q.w_lane)
          begin
            case (s_q.aw_idx)
              drpc_pkg::IDX_REF_CTRL:
              begin
                s_d.ref_en = s_q.w_byte[drpc_pkg::REF_EN_BIT];
                s_d.prio = s_q.w_byte[drpc_pkg::PRIO_LSB +: drpc_pkg::PRIO_W];
              end
              drpc_pkg::IDX_BW_LOW: s_d.bw[0 +: BW] = s_q.w_byte;
              drpc_pkg::IDX_BW_MID: s_d.bw[BW +: BW] = s_q.w_byte;
              drpc_pkg::IDX_BW_TOP:
              begin
                s_d.bw[drpc_pkg::BW_W-1] = s_q.w_byte[drpc_pkg::BW_TOP_BIT];
                s_d.filt = s_q.w_byte[drpc_pkg::FILT_BIT];
              end
              drpc_pkg::IDX_INT_LOW: s_d.ndiv[0 +: BW] = s_q.w_byte;
              drpc_pkg::IDX_INT_MID: s_d.ndiv[BW +: BW] = s_q.w_byte;
              drpc_pkg::IDX_INT_TOP:
                s_d.ndiv[2*BW +: drpc_pkg::INT_TOP_W] = s_q.w_byte[drpc_pkg::INT_TOP_W-1:0];
              drpc_pkg::IDX_NUM_LOW: s_d.num[0 +: BW] = s_q.w_byte;
              drpc_pkg::IDX_NUM_MID: s_d.num[BW +: BW] = s_q.w_byte;
              drpc_pkg::IDX_NUM_HIGH: s_d.num[2*BW +: BW] = s_q.w_byte;
              drpc_pkg::IDX_MOD_LOW: s_d.modulus[0 +: BW] = s_q.w_byte;
              drpc_pkg::IDX_MOD_MID: s_d.modulus[BW +: BW] = s_q.w_byte;
              drpc_pkg::IDX_MOD_HIGH: s_d.modulus[2*BW +: BW] = s_q.w_byte;
              default: s_d.ref_en = s_q.ref_en;
            endcase
          end
          s_d.bresp = s_q.aw_hit ? drpc_pkg::RESP_OKAY : drpc_pkg::RESP_SLVERR;
          s_d.bvalid = 1'b1;
          s_d.aw_held = 1'b0;
          s_d.w_held = 1'b0;
          s_d.wst = drpc_pkg::DRPC_WR_RESP;
        end
      end
      drpc_pkg::DRPC_WR_RESP:
      begin
        if (s_axi_bready)
        begin
          s_d.bvalid = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready = 1'b1;
          s_d.wst = drpc_pkg::DRPC_WR_IDLE;
        end
      end
      default: s_d.wst = drpc_pkg::DRPC_WR_IDLE;
    endcase
    s_d.bypass = (s_d.modulus == '0);
    // read channel, data one edge after the address
    case (s_q.rst)
      drpc_pkg::DRPC_RD_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          s_d.arready = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.rdata = {{(drpc_pkg::DATA_W-BW){1'b0}},
            reg_byte(s_q, addr_idx(s_axi_araddr))};
          s_d.rresp = addr_hit(s_axi_araddr) ? drpc_pkg::RESP_OKAY : drpc_pkg::RESP_SLVERR;
          s_d.rst = drpc_pkg::DRPC_RD_DATA;
        end
      end
      drpc_pkg::DRPC_RD_DATA:
      begin
        if (s_axi_rready)
        begin
          s_d.rvalid = 1'b0;
          s_d.arready = 1'b1;
          s_d.rst = drpc_pkg::DRPC_RD_IDLE;
        end
      end
      default: s_d.rst = drpc_pkg::DRPC_RD_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= ST_RST;
    else if (ce)
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign lock_permit = s_q.ref_en;
  assign ref_priority = s_q.prio;
  assign bw_scale = s_q.bw;
  assign filter_high_pm = s_q.filt;
  assign int_div_field = s_q.ndiv;
  assign frac_numerator = s_q.num;
  assign frac_modulus = s_q.modulus;
  assign frac_bypass = s_q.bypass;

  drpc_frac_div #(
    .INT_W(drpc_pkg::INT_W),
    .FRAC_W(drpc_pkg::FRAC_W)
  ) u_frac (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .fb_tick(fb_tick),
    .int_field(s_q.ndiv),
    .num(s_q.num),
    .modulus(s_q.modulus),
    .ratio(fb_ratio),
    .carry(fb_carry)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bw_low_write: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_BW_LOW
    |=> bw_scale[7:0] == $past(s_q.w_byte) && bw_scale[16:8] == $past(bw_scale[16:8]))
    else $error("bandwidth low byte not stored");
  a_bw_top_bit: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_BW_TOP
    |=> bw_scale[16] == $past(s_q.w_byte[0]) && bw_scale[15:0] == $past(bw_scale[15:0]))
    else $error("bandwidth bit 16 not stored");
  a_filter_select: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_BW_TOP
    |=> filter_high_pm == $past(s_q.w_byte[1]))
    else $error("filter select not taken from bit 1");
  a_int_div_top: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_INT_TOP
    |=> int_div_field[17:16] == $past(s_q.w_byte[1:0]))
    else $error("divisor top bits not stored");
  a_num_high_byte: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_NUM_HIGH
    |=> frac_numerator[23:16] == $past(s_q.w_byte)
    && frac_numerator[15:0] == $past(frac_numerator[15:0]))
    else $error("numerator high byte misplaced");
  a_mod_bypass: assert property (frac_bypass == (frac_modulus == '0))
    else $error("bypass flag disagrees with modulus");
  a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    bw_scale == '0 && int_div_field == '0 && frac_numerator == '0 && frac_modulus == '0
    && !lock_permit && !filter_high_pm)
    else $error("fields not cleared by reset");
  a_lock_enable: assert property (wr_fire && s_q.aw_idx == drpc_pkg::IDX_REF_CTRL
    |=> lock_permit == $past(s_q.w_byte[0]))
    else $error("reference enable not stored");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:8] == '0)
    else $error("read answer late or upper bits set");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_frac_on: cover property (!frac_bypass && fb_tick ##1 fb_carry);

endmodule
`default_nettype wire

/* File: verification/test_dpll_ref_profile_config.sv */
// self-checking bench for the reference profile register bank
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, (a), (b)); end end
module test_dpll_ref_profile_config;
  logic aclk;
  logic aresetn;
  logic ce;
  logic [15:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [15:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic fb_tick;
  logic lock_permit;
  logic [1:0] ref_priority;
  logic [16:0] bw_scale;
  logic filter_high_pm;
  logic [17:0] int_div_field;
  logic [23:0] frac_numerator;
  logic [23:0] frac_modulus;
  logic frac_bypass;
  logic [18:0] fb_ratio;
  logic fb_carry;
  int n_fail = 0;
  int checks = 0;
  localparam logic [1:0] OK = drpc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = drpc_pkg::RESP_SLVERR;

  drpc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fb_tick(fb_tick), .lock_permit(lock_permit),
    .ref_priority(ref_priority), .bw_scale(bw_scale), .filter_high_pm(filter_high_pm),
    .int_div_field(int_div_field), .frac_numerator(frac_numerator),
    .frac_modulus(frac_modulus), .frac_bypass(frac_bypass), .fb_ratio(fb_ratio),
    .fb_carry(fb_carry));

  // 125 mhz system clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // byte address of a register index
  function automatic logic [15:0] ba(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // one axi4-lite write, response compared with the expected code
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= ba(idx);
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        got = 1'b1;
        bready <= 1'b0;
        `chk(bresp, er)
      end
    end
  endtask

  // one axi4-lite read, data and response compared
  task automatic rd(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        got = 1'b1;
        rready <= 1'b0;
        `chk(rdata, {24'h000000, ed})
        `chk(rresp, er)
      end
    end
  endtask

  // one feedback cycle boundary, outputs sampled mid-cycle
  task automatic tick();
    @(posedge aclk);
    fb_tick <= 1'b1;
    @(posedge aclk);
    fb_tick <= 1'b0;
    @(negedge aclk);
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial
  begin
    int acc;
    logic [18:0] er;
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    fb_tick = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset state at the ports and in every register
    `chk({bw_scale, int_div_field, frac_numerator, frac_modulus}, 83'h0)
    `chk({filter_high_pm, lock_permit, ref_priority}, 4'h0)
    `chk({frac_bypass, fb_ratio, fb_carry}, {1'b1, 19'h00001, 1'b0})
    for (int i = 0; i < 13; i++) rd(12'(drpc_pkg::IDX_REF_CTRL + i), 8'h00, OK);
    // bandwidth bytes, top bit shares a byte with the filter select
    // 7 kHz setting, loop assumed fast enough, high margin filter first
    wr(drpc_pkg::IDX_BW_LOW, 8'h34, 4'h1, OK);
    wr(drpc_pkg::IDX_BW_MID, 8'h12, 4'h1, OK);
    wr(drpc_pkg::IDX_BW_TOP, 8'hff, 4'h1, OK);
    `chk({bw_scale, filter_high_pm}, {17'h11234, 1'b1})
    rd(drpc_pkg::IDX_BW_TOP, 8'h03, OK);
    wr(drpc_pkg::IDX_BW_TOP, 8'h01, 4'h1, OK);
    `chk({bw_scale, filter_high_pm}, {17'h11234, 1'b0})
    // masked strobe stores nothing
    wr(drpc_pkg::IDX_BW_LOW, 8'h55, 4'h0, OK);
    `chk(bw_scale, 17'h11234)
    // integer divisor stored minus one, bypassed fraction
    wr(drpc_pkg::IDX_INT_LOW, 8'hfe, 4'h1, OK);
    wr(drpc_pkg::IDX_INT_MID, 8'hff, 4'h1, OK);
    wr(drpc_pkg::IDX_INT_TOP, 8'hff, 4'h1, OK);
    rd(drpc_pkg::IDX_INT_TOP, 8'h03, OK);
    `chk(int_div_field, 18'h3fffe)
    tick();
    `chk({fb_ratio, fb_carry}, {19'h3ffff, 1'b0})
    wr(drpc_pkg::IDX_INT_LOW, 8'h00, 4'h1, OK);
    wr(drpc_pkg::IDX_INT_MID, 8'h00, 4'h1, OK);
    wr(drpc_pkg::IDX_INT_TOP, 8'h00, 4'h1, OK);
    tick();
    `chk(fb_ratio, 19'h00001)
    wr(drpc_pkg::IDX_INT_LOW, 8'h09, 4'h1, OK);
    // numerator byte order
    wr(drpc_pkg::IDX_NUM_LOW, 8'h01, 4'h1, OK);
    wr(drpc_pkg::IDX_NUM_MID, 8'h02, 4'h1, OK);
    wr(drpc_pkg::IDX_NUM_HIGH, 8'h03, 4'h1, OK);
    `chk(frac_numerator, 24'h030201)
    rd(drpc_pkg::IDX_NUM_HIGH, 8'h03, OK);
    wr(drpc_pkg::IDX_NUM_MID, 8'h00, 4'h1, OK);
    wr(drpc_pkg::IDX_NUM_HIGH, 8'h00, 4'h1, OK);
    // modulus byte order and bypass on zero
    wr(drpc_pkg::IDX_MOD_HIGH, 8'ha0, 4'h1, OK);
    `chk({frac_modulus, frac_bypass}, {24'ha00000, 1'b0})
    wr(drpc_pkg::IDX_MOD_HIGH, 8'h00, 4'h1, OK);
    `chk(frac_bypass, 1'b1)
    wr(drpc_pkg::IDX_MOD_LOW, 8'h03, 4'h1, OK);
    `chk({frac_modulus, frac_bypass}, {24'h000003, 1'b0})
    // ratio sequence 10 + 1/3 over successive feedback cycles
    acc = 0;
    for (int k = 0; k < 6; k++)
    begin
      acc = acc + 1;
      er = (acc >= 3) ? 19'd11 : 19'd10;
      tick();
      `chk({fb_ratio, fb_carry}, {er, acc >= 3})
      if (acc >= 3) acc = acc - 3;
    end
    // clock enable low freezes the sequencer on its last carry step
    @(posedge aclk);
    ce <= 1'b0;
    tick();
    `chk({fb_ratio, fb_carry}, {19'd11, 1'b1})
    @(posedge aclk);
    ce <= 1'b1;
    // reference enable and priority
    wr(drpc_pkg::IDX_REF_CTRL, 8'hff, 4'h1, OK);
    `chk({lock_permit, ref_priority}, 3'h7)
    rd(drpc_pkg::IDX_REF_CTRL, 8'h07, OK);
    wr(drpc_pkg::IDX_REF_CTRL, 8'h00, 4'h1, OK);
    `chk(lock_permit, 1'b0)
    // unmapped place refused and leaves neighbours alone
    wr(12'h44d, 8'hff, 4'h1, ERR);
    rd(12'h44d, 8'h00, ERR);
    rd(drpc_pkg::IDX_MOD_HIGH, 8'h00, OK);
    rd(drpc_pkg::IDX_MOD_LOW, 8'h03, OK);
    // mid-run reset clears every field again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `chk({bw_scale, int_div_field, frac_numerator, frac_modulus}, 83'h0)
    `chk({frac_bypass, fb_ratio, filter_high_pm}, {1'b1, 19'h00001, 1'b0})
    rd(drpc_pkg::IDX_MOD_LOW, 8'h00, OK);
    finish_test();
  end
endmodule
`default_nettype wire
